// >>> otp_pkg.sv
// package for the one-time-programmable parameter store
// shared by the store top, the bank picker and the field extractor
package otp_pkg;
  localparam int BANK_COUNT = 6;
  localparam int BANK_BITS = 128;
  localparam int STORE_BITS = 768;
  localparam int FIXED_BITS = 108;
  localparam int GP_BITS = 20;
  localparam int SEL_W = 3;
  localparam int WORD_W = 32;
  localparam int WORDS_PER_BANK = 4;
  // field positions inside one bank; layout figure not available, so plain choices
  localparam int POS_BANK_VALID = 0;
  localparam int POS_BANK_RETIRED = 1;
  localparam int POS_ADDR_VALID = 2;
  localparam int POS_ADDR = 3;
  localparam int ADDR_W = 48;
  localparam int POS_CONV_VALID = 51;
  localparam int POS_CONV = 52;
  localparam int CONV_W = 16;
  localparam int POS_XTAL_VALID = 68;
  localparam int POS_XTAL = 69;
  localparam int XTAL_W = 15;
  localparam int POS_GAIN_VALID = 84;
  localparam int POS_GAIN = 85;
  localparam int GAIN_W = 11;
  localparam int POS_PHASE_VALID = 96;
  localparam int POS_PHASE = 97;
  localparam int PHASE_W = 11;
  localparam int POS_GP = 108;
  localparam logic [SEL_W-1:0] BANK_FALLBACK = 3'h0;
  // register port map, word indices
  localparam logic [7:0] ADDR_STORE_BASE = 8'h00;
  localparam logic [7:0] ADDR_STORE_LAST = 8'h17;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_CTRL = 8'h21;
  localparam logic [7:0] ADDR_ADDR_LO = 8'h22;
  localparam logic [7:0] ADDR_ADDR_HI = 8'h23;
  localparam logic [7:0] ADDR_ADDR2_LO = 8'h24;
  localparam logic [7:0] ADDR_ADDR2_HI = 8'h25;
  localparam logic [7:0] ADDR_CAL = 8'h26;
  localparam logic [7:0] ADDR_IMB = 8'h27;
  localparam logic [WORD_W-1:0] CTRL_RESET = 32'h0000_0001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_READY = 2'b10
  } init_state_t;

  typedef struct packed {
    logic addr_ok;
    logic [ADDR_W-1:0] addr;
    logic conv_ok;
    logic [CONV_W-1:0] conv;
    logic xtal_ok;
    logic [XTAL_W-1:0] xtal;
    logic gain_ok;
    logic [GAIN_W-1:0] gain_imbalance_trim;
    logic phase_ok;
    logic [PHASE_W-1:0] phase_imbalance_trim;
  } params_t;
endpackage : otp_pkg

// >>> bank_pick.sv
// picks the live bank from the per-bank valid and retired flags
// assumes the fuse image is stable while read
`timescale 1ns/100ps
module bank_pick (
  input wire logic [otp_pkg::STORE_BITS-1:0] i_store,
  output logic [otp_pkg::SEL_W-1:0] o_sel,
  output logic o_found
);
  logic [otp_pkg::BANK_COUNT-1:0] live;

  genvar g;
  generate
    for (g = 0; g < otp_pkg::BANK_COUNT; g++) begin : g_live
      assign live[g] = i_store[g*otp_pkg::BANK_BITS + otp_pkg::POS_BANK_VALID] &
                       ~i_store[g*otp_pkg::BANK_BITS + otp_pkg::POS_BANK_RETIRED];
    end
  endgenerate

  always_comb begin
    o_sel = otp_pkg::BANK_FALLBACK;
    o_found = 1'b0;
    for (int b = 0; b < otp_pkg::BANK_COUNT; b++) begin
      if (live[b]) begin
        o_sel = b[otp_pkg::SEL_W-1:0];
        o_found = 1'b1;
      end
    end
  end
endmodule : bank_pick

// >>> field_extract.sv
// splits one bank into its fixed-purpose fields, gated by their validity bits
// assumes the bank layout held in the package
`timescale 1ns/100ps
module field_extract (
  input wire logic [otp_pkg::BANK_BITS-1:0] i_bank,
  input wire logic i_current_mode,
  output otp_pkg::params_t o_params
);
  logic imb_ok;

  always_comb begin
    // both imbalance flags must be set; legacy mode never looks at them
    imb_ok = i_current_mode & i_bank[otp_pkg::POS_GAIN_VALID] &
             i_bank[otp_pkg::POS_PHASE_VALID];
    o_params.addr_ok = i_bank[otp_pkg::POS_ADDR_VALID];
    o_params.addr = o_params.addr_ok ?
                    i_bank[otp_pkg::POS_ADDR +: otp_pkg::ADDR_W] : '0;
    o_params.conv_ok = i_bank[otp_pkg::POS_CONV_VALID];
    o_params.conv = o_params.conv_ok ?
                    i_bank[otp_pkg::POS_CONV +: otp_pkg::CONV_W] : '0;
    o_params.xtal_ok = i_bank[otp_pkg::POS_XTAL_VALID];
    o_params.xtal = o_params.xtal_ok ?
                    i_bank[otp_pkg::POS_XTAL +: otp_pkg::XTAL_W] : '0;
    o_params.gain_ok = imb_ok;
    o_params.gain_imbalance_trim = imb_ok ?
                    i_bank[otp_pkg::POS_GAIN +: otp_pkg::GAIN_W] : '0;
    o_params.phase_ok = imb_ok;
    o_params.phase_imbalance_trim = imb_ok ?
                    i_bank[otp_pkg::POS_PHASE +: otp_pkg::PHASE_W] : '0;
  end
endmodule : field_extract

// >>> otp_param_store.sv
// parameter store top: samples the fuse array, picks a bank, exposes parameters
// assumes i_fuse is the static fuse array image, stable from reset release
// How it works
// - 768 fuse bits are readable by the processor after reset release.
// - six identical 128-bit banks numbered zero to five.
// - lowest 108 bits are fixed fields; top 20 bits carry no hardware meaning.
// - secondary address equals selected station address plus one, unsigned.
// - each field has a validity bit; one means usable, zero means ignored; the secondary address still uses the station address when its bit is zero.
// - bank zero ships holding converter and imbalance trims, maybe station address.
// - current mode loads both imbalance trims only when both validity bits set.
// - legacy mode never applies imbalance trims nor checks their bits.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module otp_param_store (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [otp_pkg::STORE_BITS-1:0] i_fuse,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_ready,
  output logic [otp_pkg::SEL_W-1:0] o_bank,
  output otp_pkg::params_t o_params,
  output logic [otp_pkg::ADDR_W-1:0] o_addr2
);
  // fuse image, taken once after reset so later reads are stable
  logic [otp_pkg::STORE_BITS-1:0] image_q, image_d;
  otp_pkg::init_state_t state_q, state_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [otp_pkg::SEL_W-1:0] bank_q, bank_d;
  logic found_q, found_d;
  otp_pkg::params_t params_q, params_d;
  logic [otp_pkg::ADDR_W-1:0] addr2_q, addr2_d;
  logic [31:0] rdata_q, rdata_d;

  logic [otp_pkg::SEL_W-1:0] pick_sel;
  logic pick_found;
  logic [otp_pkg::BANK_BITS-1:0] sel_bank;
  otp_pkg::params_t ext_params;

  bank_pick u_pick (
    .i_store(image_q),
    .o_sel(pick_sel),
    .o_found(pick_found)
  );

  // banks are equal slices, fixed fields from package positions
  assign sel_bank = image_q[pick_sel*otp_pkg::BANK_BITS +: otp_pkg::BANK_BITS];

  field_extract u_extract (
    .i_bank(sel_bank),
    .i_current_mode(ctrl_q[0]),
    .o_params(ext_params)
  );

  function automatic logic [31:0] store_word(
    input logic [otp_pkg::STORE_BITS-1:0] img,
    input logic [7:0] idx
  );
    logic [4:0] w;
    w = idx[4:0];
    return img[w*otp_pkg::WORD_W +: otp_pkg::WORD_W];
  endfunction : store_word

  // init sequence: sample, select, then hold
  always_comb begin
    state_d = state_q;
    image_d = image_q;
    bank_d = bank_q;
    found_d = found_q;
    params_d = params_q;
    addr2_d = addr2_q;
    case (state_q)
      otp_pkg::ST_IDLE: begin
        image_d = i_fuse;
        state_d = otp_pkg::ST_LOAD;
      end
      otp_pkg::ST_LOAD: begin
        bank_d = pick_sel;
        found_d = pick_found;
        params_d = ext_params;
        // secondary address is derived regardless of the validity bit
        addr2_d = image_q[pick_sel*otp_pkg::BANK_BITS + otp_pkg::POS_ADDR +: otp_pkg::ADDR_W]
                  + 48'h0000_0000_0001;
        state_d = otp_pkg::ST_READY;
      end
      otp_pkg::ST_READY: begin
        // a mode change reruns selection so the trims follow it
        if (i_wr && i_addr == otp_pkg::ADDR_CTRL && i_wdata[0] != ctrl_q[0]) begin
          state_d = otp_pkg::ST_LOAD;
        end
      end
      default: state_d = otp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= otp_pkg::ST_IDLE;
      image_q <= '0;
      bank_q <= otp_pkg::BANK_FALLBACK;
      found_q <= 1'b0;
      params_q <= '0;
      addr2_q <= '0;
    end else begin
      state_q <= state_d;
      image_q <= image_d;
      bank_q <= bank_d;
      found_q <= found_d;
      params_q <= params_d;
      addr2_q <= addr2_d;
    end
  end

  // register port
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = 32'h0000_0000;
    if (i_wr && i_addr == otp_pkg::ADDR_CTRL) begin
      ctrl_d = {31'h0000_0000, i_wdata[0]};
    end
    if (i_rd) begin
      if (i_addr <= otp_pkg::ADDR_STORE_LAST) begin
        rdata_d = store_word(image_q, i_addr);
      end else begin
        case (i_addr)
          otp_pkg::ADDR_STATUS: rdata_d = {24'h00_0000, found_q, bank_q,
                                           state_q == otp_pkg::ST_READY, 3'h0};
          otp_pkg::ADDR_CTRL: rdata_d = ctrl_q;
          otp_pkg::ADDR_ADDR_LO: rdata_d = params_q.addr[31:0];
          otp_pkg::ADDR_ADDR_HI: rdata_d = {15'h0000, params_q.addr_ok, params_q.addr[47:32]};
          otp_pkg::ADDR_ADDR2_LO: rdata_d = addr2_q[31:0];
          otp_pkg::ADDR_ADDR2_HI: rdata_d = {16'h0000, addr2_q[47:32]};
          // fields total 33 bits; the top crystal bit is left out on purpose so the word holds 32
          otp_pkg::ADDR_CAL: rdata_d = {params_q.conv_ok, params_q.conv,
                                        params_q.xtal_ok, params_q.xtal[13:0]};
          otp_pkg::ADDR_IMB: rdata_d = {8'h00, params_q.gain_ok, params_q.gain_imbalance_trim,
                                        params_q.phase_ok,
                                        params_q.phase_imbalance_trim};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= otp_pkg::CTRL_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_ready = (state_q == otp_pkg::ST_READY);
  assign o_bank = bank_q;
  assign o_params = params_q;
  assign o_addr2 = addr2_q;
endmodule : otp_param_store

// >>> store_chk.sv
// port-level checker for the parameter store
// assumes the fuse image only changes while reset is held
`timescale 1ns/100ps
module store_chk (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [767:0] i_fuse,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_ready,
  input wire logic [2:0] o_bank,
  input wire otp_pkg::params_t o_params,
  input wire logic [47:0] o_addr2
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [127:0] sel;
  assign sel = i_fuse[o_bank*128 +: 128];
  addr2_sum_a: assert property (o_ready |-> o_addr2 == sel[3 +: 48] + 48'h1)
    else $error("addr2 wrong");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("rdata not idle");
  store_rd_a: assert property (i_rd && i_addr <= 8'h17 |=>
    o_rdata == $past(i_fuse[i_addr*32 +: 32])) else $error("store word wrong");
  unmapped_rd_a: assert property (i_rd && i_addr inside {[8'h18:8'h1f]} |=>
    o_rdata == 32'h0) else $error("unmapped read");
  trim_pair_a: assert property (o_ready |-> o_params.gain_ok == o_params.phase_ok)
    else $error("trim pair split");
  trim_gate_a: assert property (o_ready && !o_params.gain_ok |->
    o_params.gain_imbalance_trim == 11'h0) else $error("gain not cleared");
  addr_ok_a: assert property (o_ready |-> o_params.addr_ok == sel[2])
    else $error("addr validity");
  bank_live_a: assert property (o_ready && o_bank != 3'h0 |-> sel[0] && !sel[1])
    else $error("bank not live");
  boot_ready_a: assert property (!$past(i_nrst) |-> !o_ready ##1 !o_ready ##1 o_ready)
    else $error("ready timing");
  cover property (o_ready && o_bank == 3'h3);
  cover property (o_ready && !o_params.gain_ok && o_params.conv_ok);
  cover property (o_ready && o_bank == 3'h0);
endmodule : store_chk
bind otp_param_store store_chk u_store_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_fuse(i_fuse), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ready(o_ready),
  .o_bank(o_bank), .o_params(o_params), .o_addr2(o_addr2));

// >>> cpu_model.sv
// processor model issuing register strobes
// assumes read data stand only in the cycle after the strobe
`timescale 1ns/100ps
module cpu_model (
  input wire logic i_clock,
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
  endtask : wr
endmodule : cpu_model

// >>> otp_param_store_tb.sv
// testbench: boots fuse images and checks picked bank and fields
// assumes the processor model carries all register traffic
`timescale 1ns/100ps
module otp_param_store_tb;
  logic clk, nrst, wr, rd, ready;
  logic [767:0] fuse, img;
  logic [7:0] addr;
  logic [31:0] wd, rdata, d;
  logic [2:0] bank;
  logic [47:0] addr2;
  otp_pkg::params_t prm;
  int n_errors = 0;
  int tests_run = 0;
  otp_param_store u_otp_param_store (.i_clock(clk), .i_nrst(nrst), .i_fuse(fuse),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_ready(ready), .o_bank(bank), .o_params(prm), .o_addr2(addr2));
  cpu_model u_cpu_model (.i_clock(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string nm);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // general bits all ones: they must not affect anything
  function automatic logic [127:0] bk(logic v, logic r, logic [47:0] a, logic g, logic p);
    bk = {20'hf_ffff, 11'h155, p, 11'h2aa, g, 15'h1234, 1'b1, 16'habcd, 1'b1, a, 1'b1, r, v};
  endfunction : bk
  task automatic boot(input logic [767:0] f);
    nrst <= 1'b0;
    fuse <= f;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : boot
  task automatic t_fallback();
    img = {640'h0, bk(1'b0, 1'b0, 48'h0012_3456_789a, 1'b1, 1'b1)};
    boot(img);
    chk(bank, 3'h0, "bank");
    chk(addr2, 48'h0012_3456_789b, "addr2");
    chk(prm.gain_imbalance_trim, 11'h2aa, "gain");
    u_cpu_model.rd(8'h03, d);
    chk(d, img[127:96], "word3");
    u_cpu_model.rd(8'h18, d);
    chk(d, 32'h0, "unmapped");
    u_cpu_model.rd(8'h20, d);
    chk(d, 32'h0000_0008, "status");
    u_cpu_model.rd(8'h22, d);
    chk(d, 32'h3456_789a, "addr_lo");
    u_cpu_model.rd(8'h26, d);
    chk(d, 32'hd5e6_d234, "cal");
    u_cpu_model.rd(8'h27, d);
    chk(d, 32'h00aa_a955, "imb");
  endtask : t_fallback
  // bank 5 retired, bank 3 the highest live bank above bank 2: the pick order seen at the bank output port
  task automatic t_pick();
    img = {bk(1'b1, 1'b1, 48'h5, 1'b1, 1'b1), bk(1'b0, 1'b0, 48'h4, 1'b1, 1'b1),
      bk(1'b1, 1'b0, 48'hffff_ffff_ffff, 1'b1, 1'b0), bk(1'b1, 1'b0, 48'h2, 1'b1, 1'b1),
      128'h0, bk(1'b0, 1'b0, 48'h1, 1'b1, 1'b1)};
    boot(img);
    chk(bank, 3'h3, "bank");
    chk(addr2, 48'h0, "addr2");
    chk(prm.gain_ok, 1'b0, "gain_ok");
  endtask : t_pick
  task automatic t_legacy();
    boot({640'h0, bk(1'b0, 1'b0, 48'h7, 1'b1, 1'b1)});
    u_cpu_model.wr(8'h21, 32'h0000_0000);
    repeat (3) @(posedge clk);
    #1;
    chk(prm.gain_ok, 1'b0, "gain_ok");
    chk(prm.conv_ok, 1'b1, "conv_ok");
    u_cpu_model.rd(8'h21, d);
    chk(d, 32'h0, "ctrl");
    u_cpu_model.wr(8'h21, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1;
    chk(prm.gain_ok, 1'b1, "gain_ok");
  endtask : t_legacy
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    t_fallback();
    t_pick();
    t_legacy();
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule : otp_param_store_tb
